// >>> design/cai_pkg.sv
package cai_pkg;

    // ------------------------------------------------------------
    // Widths of the programming model
    // ------------------------------------------------------------
    localparam int ACC_W = 8;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int OFFS_W = 8;
    localparam int FLAG_W = 8;

    // ------------------------------------------------------------
    // Flag register bit positions
    // ------------------------------------------------------------
    localparam int FL_C = 0;
    localparam int FL_V = 1;
    localparam int FL_Z = 2;
    localparam int FL_N = 3;
    localparam int FL_I = 4;
    localparam int FL_H = 5;
    localparam int FL_X = 6;
    localparam int FL_S = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [FLAG_W-1:0] FLAGS_RST = 8'hD0;
    localparam logic [ACC_W-1:0] ACC_RST = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

    // ------------------------------------------------------------
    // Decimal adjust constants
    // ------------------------------------------------------------
    localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
    localparam logic [ACC_W-1:0] BCD_MAX_BYTE = 8'h99;
    localparam logic [3:0] BCD_FIX = 4'h6;

    // ------------------------------------------------------------
    // Operations accepted from the instruction stream
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NOP            = 5'h00,
        OP_LOAD_ACCA      = 5'h01,
        OP_LOAD_ACCB      = 5'h02,
        OP_LOAD_PAIR      = 5'h03,
        OP_LOAD_INDEX_ONE = 5'h04,
        OP_LOAD_INDEX_TWO = 5'h05,
        OP_LOAD_STACK     = 5'h06,
        OP_LOAD_PC        = 5'h07,
        OP_ADD_ACCB_IX1   = 5'h08,
        OP_ADD_ACCB_IX2   = 5'h09,
        OP_MOVE_ACCA_FL   = 5'h0A,
        OP_MOVE_FL_ACCA   = 5'h0B,
        OP_DECIMAL_ADJUST = 5'h0C,
        OP_ADD_ACCS       = 5'h0D,
        OP_SUB_ACCS       = 5'h0E,
        OP_CMP_ACCS       = 5'h0F,
        OP_INC_INDEX_ONE  = 5'h10,
        OP_DEC_INDEX_ONE  = 5'h11,
        OP_ADDR_INDEX_ONE = 5'h12,
        OP_ADDR_INDEX_TWO = 5'h13
    } cai_op_t;

    // Sequencer: second index add/address ops spend one extra cycle
    typedef enum logic [0:0] {
        ST_IDLE    = 1'b0,
        ST_PREBYTE = 1'b1
    } cai_state_t;

endpackage : cai_pkg

// >>> design/cai_regs.sv
`timescale 1ns/10ps

// Behaviour
// - One 64-Kbyte map for memory and peripherals
// - No separate I/O operations exist
// - Operand address latency independent of location
// - Core registers never appear in address map
// - Exactly seven core registers
// - Two 8-bit general accumulators
// - Pair view is concatenation, no storage
// - Only second accumulator adds into index
// - Flag moves exist only for first accumulator
// - Decimal adjust only on first accumulator
// - Accumulator add/sub/compare one direction only
// - Address is either index plus offset
// - First index also counts or holds data
// - Second index add/address ops take one extra cycle
// - Flag register is 8 bits
module cai_regs (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire cai_pkg::cai_op_t op_code,
    input wire logic [cai_pkg::WORD_W-1:0] op_data,
    input wire logic [cai_pkg::OFFS_W-1:0] op_offset,
    output logic op_ready,
    output logic [cai_pkg::ACC_W-1:0] acc_one,
    output logic [cai_pkg::ACC_W-1:0] acc_two,
    output logic [cai_pkg::WORD_W-1:0] acc_pair,
    output logic [cai_pkg::WORD_W-1:0] index_reg_one,
    output logic [cai_pkg::WORD_W-1:0] index_reg_two,
    output logic [cai_pkg::WORD_W-1:0] stack_ptr,
    output logic [cai_pkg::WORD_W-1:0] prog_ctr,
    output logic [cai_pkg::FLAG_W-1:0] condition_flags_register,
    output logic [cai_pkg::ADDR_W-1:0] ea_addr,
    output logic ea_valid
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // The seven registers; nothing else holds architectural state
    logic [cai_pkg::ACC_W-1:0] acca_r, acca_nxt, accb_r, accb_nxt;
    logic [cai_pkg::WORD_W-1:0] ix1_r, ix1_nxt, ix2_r, ix2_nxt;
    logic [cai_pkg::WORD_W-1:0] sp_r, sp_nxt, pc_r, pc_nxt;
    logic [cai_pkg::FLAG_W-1:0] flags_r, flags_nxt;
    // Sequencing and address output
    cai_pkg::cai_state_t state_r, state_nxt;
    cai_pkg::cai_op_t pend_op_r, pend_op_nxt;
    logic [cai_pkg::OFFS_W-1:0] pend_off_r, pend_off_nxt;
    logic [cai_pkg::ADDR_W-1:0] ea_r, ea_nxt;
    logic ea_valid_r, ea_valid_nxt;
    logic take, uses_two, exec_en;
    cai_pkg::cai_op_t exec_op;
    logic [cai_pkg::OFFS_W-1:0] exec_off;
    logic [cai_pkg::ACC_W:0] sum9, diff9;
    logic lo_fix, hi_fix;
    logic [cai_pkg::ACC_W-1:0] bcd_res;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Second index add/address ops hold the port one cycle, as a prebyte would
    assign op_ready = (state_r == cai_pkg::ST_IDLE);
    assign take = op_valid && op_ready;
    assign uses_two = (op_code == cai_pkg::OP_ADD_ACCB_IX2) || (op_code == cai_pkg::OP_ADDR_INDEX_TWO);
    assign exec_en = (state_r == cai_pkg::ST_PREBYTE) || (take && !uses_two);
    assign exec_op = (state_r == cai_pkg::ST_PREBYTE) ? pend_op_r : op_code;
    assign exec_off = (state_r == cai_pkg::ST_PREBYTE) ? pend_off_r : op_offset;

    always_comb
    begin
        state_nxt = state_r;
        pend_op_nxt = pend_op_r;
        pend_off_nxt = pend_off_r;
        case (state_r)
            cai_pkg::ST_IDLE:
                if (take && uses_two)
                begin
                    state_nxt = cai_pkg::ST_PREBYTE;
                    pend_op_nxt = op_code;
                    pend_off_nxt = op_offset;
                end
            cai_pkg::ST_PREBYTE: state_nxt = cai_pkg::ST_IDLE;
            default: state_nxt = cai_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    // Fixed direction: always first minus / plus second
    assign sum9 = {1'b0, acca_r} + {1'b0, accb_r};
    assign diff9 = {1'b0, acca_r} - {1'b0, accb_r};
    // Decimal correction works from the half-carry and carry flags
    assign lo_fix = flags_r[cai_pkg::FL_H] || (acca_r[3:0] > cai_pkg::BCD_MAX_DIGIT);
    assign hi_fix = flags_r[cai_pkg::FL_C] || (acca_r > cai_pkg::BCD_MAX_BYTE);
    assign bcd_res = acca_r + {(hi_fix ? cai_pkg::BCD_FIX : 4'h0), (lo_fix ? cai_pkg::BCD_FIX : 4'h0)};

    // Next values of registers and address output
    always_comb
    begin
        acca_nxt = acca_r;
        accb_nxt = accb_r;
        ix1_nxt = ix1_r;
        ix2_nxt = ix2_r;
        sp_nxt = sp_r;
        pc_nxt = pc_r;
        flags_nxt = flags_r;
        ea_nxt = ea_r;
        ea_valid_nxt = 1'b0;
        if (exec_en)
        begin
            case (exec_op)
                cai_pkg::OP_LOAD_ACCA: acca_nxt = op_data[cai_pkg::ACC_W-1:0];
                cai_pkg::OP_LOAD_ACCB: accb_nxt = op_data[cai_pkg::ACC_W-1:0];
                cai_pkg::OP_LOAD_PAIR:
                begin
                    acca_nxt = op_data[15:8];
                    accb_nxt = op_data[7:0];
                end
                cai_pkg::OP_LOAD_INDEX_ONE: ix1_nxt = op_data;
                cai_pkg::OP_LOAD_INDEX_TWO: ix2_nxt = op_data;
                cai_pkg::OP_LOAD_STACK: sp_nxt = op_data;
                cai_pkg::OP_LOAD_PC: pc_nxt = op_data;
                // Index adds leave flags alone
                cai_pkg::OP_ADD_ACCB_IX1: ix1_nxt = ix1_r + {8'h00, accb_r};
                cai_pkg::OP_ADD_ACCB_IX2: ix2_nxt = ix2_r + {8'h00, accb_r};
                cai_pkg::OP_MOVE_ACCA_FL:
                begin
                    flags_nxt = acca_r;
                    flags_nxt[cai_pkg::FL_X] = acca_r[cai_pkg::FL_X] & flags_r[cai_pkg::FL_X]; // X clears, never sets
                end
                cai_pkg::OP_MOVE_FL_ACCA: acca_nxt = flags_r;
                cai_pkg::OP_DECIMAL_ADJUST:
                begin
                    acca_nxt = bcd_res;
                    flags_nxt[cai_pkg::FL_C] = flags_r[cai_pkg::FL_C] | hi_fix;
                    flags_nxt[cai_pkg::FL_N] = bcd_res[7];
                    flags_nxt[cai_pkg::FL_Z] = (bcd_res == 8'h00);
                    flags_nxt[cai_pkg::FL_V] = 1'b0;
                end
                cai_pkg::OP_ADD_ACCS:
                begin
                    acca_nxt = sum9[7:0];
                    flags_nxt[cai_pkg::FL_C] = sum9[8];
                    flags_nxt[cai_pkg::FL_N] = sum9[7];
                    flags_nxt[cai_pkg::FL_Z] = (sum9[7:0] == 8'h00);
                    flags_nxt[cai_pkg::FL_V] = (acca_r[7] ~^ accb_r[7]) & (acca_r[7] ^ sum9[7]);
                    flags_nxt[cai_pkg::FL_H] = acca_r[4] ^ accb_r[4] ^ sum9[4]; // Carry into bit 4
                end
                cai_pkg::OP_SUB_ACCS, cai_pkg::OP_CMP_ACCS:
                begin
                    // Compare keeps the difference in the flags only
                    if (exec_op == cai_pkg::OP_SUB_ACCS)
                        acca_nxt = diff9[7:0];
                    flags_nxt[cai_pkg::FL_C] = diff9[8];
                    flags_nxt[cai_pkg::FL_N] = diff9[7];
                    flags_nxt[cai_pkg::FL_Z] = (diff9[7:0] == 8'h00);
                    flags_nxt[cai_pkg::FL_V] = (acca_r[7] ^ accb_r[7]) & (acca_r[7] ^ diff9[7]);
                end
                cai_pkg::OP_INC_INDEX_ONE:
                begin
                    ix1_nxt = ix1_r + 16'h0001;
                    flags_nxt[cai_pkg::FL_Z] = (ix1_r == 16'hFFFF);
                end
                cai_pkg::OP_DEC_INDEX_ONE:
                begin
                    ix1_nxt = ix1_r - 16'h0001;
                    flags_nxt[cai_pkg::FL_Z] = (ix1_r == 16'h0001);
                end
                // One 16-bit address for any location; no I/O path exists
                cai_pkg::OP_ADDR_INDEX_ONE:
                begin
                    ea_nxt = ix1_r + {8'h00, exec_off};
                    ea_valid_nxt = 1'b1;
                end
                cai_pkg::OP_ADDR_INDEX_TWO:
                begin
                    ea_nxt = ix2_r + {8'h00, exec_off};
                    ea_valid_nxt = 1'b1;
                end
                default: ea_valid_nxt = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acca_r <= cai_pkg::ACC_RST;
            accb_r <= cai_pkg::ACC_RST;
            ix1_r <= cai_pkg::WORD_RST;
            ix2_r <= cai_pkg::WORD_RST;
            sp_r <= cai_pkg::WORD_RST;
            pc_r <= cai_pkg::WORD_RST;
            flags_r <= cai_pkg::FLAGS_RST;
            state_r <= cai_pkg::ST_IDLE;
            pend_op_r <= cai_pkg::OP_NOP;
            pend_off_r <= 8'h00;
            ea_r <= cai_pkg::WORD_RST;
            ea_valid_r <= 1'b0;
        end
        else
        begin
            acca_r <= acca_nxt;
            accb_r <= accb_nxt;
            ix1_r <= ix1_nxt;
            ix2_r <= ix2_nxt;
            sp_r <= sp_nxt;
            pc_r <= pc_nxt;
            flags_r <= flags_nxt;
            state_r <= state_nxt;
            pend_op_r <= pend_op_nxt;
            pend_off_r <= pend_off_nxt;
            ea_r <= ea_nxt;
            ea_valid_r <= ea_valid_nxt;
        end
    end

    // Registers reach the outside only as ports, never as addresses
    assign acc_one = acca_r;
    assign acc_two = accb_r;
    assign acc_pair = {acca_r, accb_r};
    assign index_reg_one = ix1_r;
    assign index_reg_two = ix2_r;
    assign stack_ptr = sp_r;
    assign prog_ctr = pc_r;
    assign condition_flags_register = flags_r;
    assign ea_addr = ea_r;
    assign ea_valid = ea_valid_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_take_two;
        op_valid && op_ready && uses_two;
    endsequence
    // Pair load must land upper byte in the first accumulator
    property p_pair_view;
        @(posedge core_clk) disable iff (!rst_n)
        (take && op_code == cai_pkg::OP_LOAD_PAIR)
        |=> acc_one == $past(op_data[15:8]) && acc_two == $past(op_data[7:0]);
    endproperty
    a_pair_view: assert property (p_pair_view) else $error("pair load order wrong");
    property p_ea_one;
        @(posedge core_clk) disable iff (!rst_n)
        (take && op_code == cai_pkg::OP_ADDR_INDEX_ONE)
        |=> ea_valid && ea_addr == 16'($past(ix1_r) + {8'h00, $past(op_offset)});
    endproperty
    a_ea_one: assert property (p_ea_one) else $error("index one address wrong");
    property p_ea_two;
        @(posedge core_clk) disable iff (!rst_n)
        (s_take_two and (op_code == cai_pkg::OP_ADDR_INDEX_TWO))
        |=> !op_ready && !ea_valid ##1 ea_valid && ea_addr == 16'($past(ix2_r, 2) + {8'h00, $past(op_offset, 2)});
    endproperty
    a_ea_two: assert property (p_ea_two) else $error("index two address late or wrong");
    property p_add_b_ix1;
        @(posedge core_clk) disable iff (!rst_n)
        (take && op_code == cai_pkg::OP_ADD_ACCB_IX1)
        |=> ix1_r == 16'($past(ix1_r) + {8'h00, $past(accb_r)}) && $stable(flags_r);
    endproperty
    a_add_b_ix1: assert property (p_add_b_ix1) else $error("add to index one wrong");
    property p_flags_to_a;
        @(posedge core_clk) disable iff (!rst_n)
        (take && op_code == cai_pkg::OP_MOVE_FL_ACCA) |=> acca_r == $past(flags_r) && $stable(accb_r);
    endproperty
    a_flags_to_a: assert property (p_flags_to_a) else $error("flag move wrong");
    property p_x_never_set;
        @(posedge core_clk) disable iff (!rst_n)
        !$past(flags_r[cai_pkg::FL_X]) |-> !flags_r[cai_pkg::FL_X];
    endproperty
    a_x_never_set: assert property (p_x_never_set) else $error("mask X set by software");
    property p_add_accs;
        @(posedge core_clk) disable iff (!rst_n)
        (take && op_code == cai_pkg::OP_ADD_ACCS)
        |=> acca_r == 8'($past(acca_r) + $past(accb_r)) && $stable(accb_r);
    endproperty
    a_add_accs: assert property (p_add_accs) else $error("accumulator add wrong");
    property p_cmp_accs;
        @(posedge core_clk) disable iff (!rst_n)
        (take && op_code == cai_pkg::OP_CMP_ACCS)
        |=> $stable(acca_r) && $stable(accb_r) && flags_r[cai_pkg::FL_Z] == ($past(acca_r) == $past(accb_r));
    endproperty
    a_cmp_accs: assert property (p_cmp_accs) else $error("compare wrong");
    property p_daa_b_kept;
        @(posedge core_clk) disable iff (!rst_n)
        (take && op_code == cai_pkg::OP_DECIMAL_ADJUST) |=> $stable(accb_r) ##1 op_ready;
    endproperty
    a_daa_b_kept: assert property (p_daa_b_kept) else $error("decimal adjust touched B");

endmodule : cai_regs

// >>> test/cai_mem_model.sv
`timescale 1ns/10ps

module cai_mem_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [cai_pkg::ADDR_W-1:0] ea_addr,
    input wire logic ea_valid,
    output logic [cai_pkg::ADDR_W-1:0] seen_addr
);
    // --------------------
    // Flat map decode
    // --------------------
    // One decode for memory and peripherals, no wait states for any address
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            seen_addr <= 16'h0000;
        else if (ea_valid)
            seen_addr <= ea_addr;
    end
endmodule : cai_mem_model

// >>> test/cpu_accumulator_index_regs_tb.sv
`timescale 1ns/10ps

module cpu_accumulator_index_regs_tb;
    // --------------------
    // Signals and model
    // --------------------
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    cai_pkg::cai_op_t op_code = cai_pkg::OP_NOP;
    logic [15:0] op_data = 16'h0000;
    logic [7:0] op_offset = 8'h00;
    logic op_ready, ea_valid;
    logic [7:0] acc_one, acc_two, flags, m_a, m_b, m_fl;
    logic [15:0] acc_pair, ix1, ix2, sp, pc, ea_addr, seen_addr;
    logic [15:0] m_x, m_y, m_sp, m_pc, m_ea;
    logic [15:0] daa_tab[4] = '{16'h009A, 16'h2019, 16'h0145, 16'h0099};
    logic [15:0] ari[4] = '{16'h8080, 16'h0001, 16'h5555, 16'h7F01};
    int bad_count = 0;
    int n_tests = 0;

    // Clock
    always #50 core_clk = ~core_clk;

    cai_regs DUT (
        .core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
        .op_data(op_data), .op_offset(op_offset), .op_ready(op_ready), .acc_one(acc_one),
        .acc_two(acc_two), .acc_pair(acc_pair), .index_reg_one(ix1), .index_reg_two(ix2),
        .stack_ptr(sp), .prog_ctr(pc), .condition_flags_register(flags),
        .ea_addr(ea_addr), .ea_valid(ea_valid)
    );

    cai_mem_model mem (
        .core_clk(core_clk), .rst_n(rst_n), .ea_addr(ea_addr), .ea_valid(ea_valid),
        .seen_addr(seen_addr)
    );

    // --------------------
    // Checking helpers
    // --------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    task automatic check_all;
        check({8'h00, acc_one}, {8'h00, m_a});
        check({8'h00, acc_two}, {8'h00, m_b});
        check(acc_pair, {m_a, m_b});
        check(ix1, m_x);
        check(ix2, m_y);
        check(sp, m_sp);
        check(pc, m_pc);
        check({8'h00, flags}, {8'h00, m_fl});
    endtask : check_all

    task automatic nzvc(input logic [7:0] r, input logic v, input logic c);
        m_fl[3:0] = {r[7], r == 8'h00, v, c};
    endtask : nzvc

    // Expected state after one taken operation
    task automatic model(input cai_pkg::cai_op_t op, input logic [15:0] d, input logic [7:0] o);
        logic [8:0] s;
        logic [7:0] k;
        logic c;
        k = 8'h00;
        c = m_fl[0];
        case (op)
            cai_pkg::OP_LOAD_ACCA: m_a = d[7:0];
            cai_pkg::OP_LOAD_ACCB: m_b = d[7:0];
            cai_pkg::OP_LOAD_PAIR: {m_a, m_b} = d;
            cai_pkg::OP_LOAD_INDEX_ONE: m_x = d;
            cai_pkg::OP_LOAD_INDEX_TWO: m_y = d;
            cai_pkg::OP_LOAD_STACK: m_sp = d;
            cai_pkg::OP_LOAD_PC: m_pc = d;
            cai_pkg::OP_ADD_ACCB_IX1: m_x = m_x + {8'h00, m_b};
            cai_pkg::OP_ADD_ACCB_IX2: m_y = m_y + {8'h00, m_b};
            cai_pkg::OP_MOVE_ACCA_FL: m_fl = {m_a[7], m_a[6] & m_fl[6], m_a[5:0]};
            cai_pkg::OP_MOVE_FL_ACCA: m_a = m_fl;
            cai_pkg::OP_DECIMAL_ADJUST:
            begin
                if (m_fl[5] || m_a[3:0] > 4'h9)
                    k[3:0] = 4'h6;
                if (c || m_a > 8'h99)
                begin
                    k[7:4] = 4'h6;
                    c = 1'b1;
                end
                m_a = m_a + k;
                nzvc(m_a, 1'b0, c);
            end
            cai_pkg::OP_ADD_ACCS:
            begin
                s = {1'b0, m_a} + {1'b0, m_b};
                k = {4'h0, m_a[3:0]} + {4'h0, m_b[3:0]};
                m_fl[5] = k[4];
                nzvc(s[7:0], (m_a[7] ~^ m_b[7]) & (s[7] ^ m_a[7]), s[8]);
                m_a = s[7:0];
            end
            cai_pkg::OP_SUB_ACCS, cai_pkg::OP_CMP_ACCS:
            begin
                s = {1'b0, m_a} - {1'b0, m_b};
                nzvc(s[7:0], (m_a[7] ^ m_b[7]) & (s[7] ^ m_a[7]), s[8]);
                if (op == cai_pkg::OP_SUB_ACCS)
                    m_a = s[7:0];
            end
            cai_pkg::OP_INC_INDEX_ONE, cai_pkg::OP_DEC_INDEX_ONE:
            begin
                m_x = (op == cai_pkg::OP_INC_INDEX_ONE) ? m_x + 16'h0001 : m_x - 16'h0001;
                m_fl[2] = (m_x == 16'h0000);
            end
            cai_pkg::OP_ADDR_INDEX_ONE: m_ea = m_x + {8'h00, o};
            cai_pkg::OP_ADDR_INDEX_TWO: m_ea = m_y + {8'h00, o};
            default: ;
        endcase
    endtask : model

    // --------------------
    // Request driving
    // --------------------
    // Leaves the request up so a caller can chain back to back
    task automatic issue(input cai_pkg::cai_op_t op, input logic [15:0] d, input logic [7:0] o);
        int i;
        @(negedge core_clk);
        op_valid = 1'b1;
        op_code = op;
        op_data = d;
        op_offset = o;
        i = 0;
        while (op_ready !== 1'b1 && i < 8)
        begin
            @(negedge core_clk);
            i++;
        end
        if (op_ready !== 1'b1)
        begin
            bad_count++;
            complete_run();
        end
        @(posedge core_clk);
        model(op, d, o);
    endtask : issue

    task automatic run(input cai_pkg::cai_op_t op, input logic [15:0] d, input logic [7:0] o);
        issue(op, d, o);
        @(negedge core_clk);
        op_valid = 1'b0;
        if (op == cai_pkg::OP_ADD_ACCB_IX2 || op == cai_pkg::OP_ADDR_INDEX_TWO)
        begin
            check({15'h0000, op_ready}, 16'h0000);
            check({15'h0000, ea_valid}, 16'h0000);
            @(negedge core_clk);
        end
        check_all();
        if (op == cai_pkg::OP_ADDR_INDEX_ONE || op == cai_pkg::OP_ADDR_INDEX_TWO)
        begin
            check({15'h0000, ea_valid}, 16'h0001);
            check(ea_addr, m_ea);
            @(negedge core_clk);
            check({15'h0000, ea_valid}, 16'h0000);
            check(seen_addr, m_ea);
        end
    endtask : run

    // --------------------
    // Main sequence
    // --------------------
    initial
    begin
        {m_a, m_b} = 16'h0000;
        {m_x, m_y, m_sp, m_pc, m_ea} = 80'h0;
        m_fl = cai_pkg::FLAGS_RST;
        void'($urandom(32'h0942));
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        check({15'h0000, op_ready}, 16'h0001);
        check_all();
        $display("Test reset done");
        run(cai_pkg::OP_LOAD_PAIR, 16'hA55A, 8'h00);
        run(cai_pkg::OP_MOVE_FL_ACCA, 16'h0000, 8'h00);
        run(cai_pkg::OP_LOAD_ACCA, 16'h00BF, 8'h00);
        run(cai_pkg::OP_MOVE_ACCA_FL, 16'h0000, 8'h00);
        run(cai_pkg::OP_LOAD_ACCA, 16'h00FF, 8'h00);
        run(cai_pkg::OP_MOVE_ACCA_FL, 16'h0000, 8'h00);
        run(cai_pkg::cai_op_t'(5'h1F), 16'hFFFF, 8'hFF);
        $display("Test flag moves done");
        foreach (daa_tab[i])
        begin
            run(cai_pkg::OP_LOAD_ACCA, {8'h00, daa_tab[i][15:8]}, 8'h00);
            run(cai_pkg::OP_MOVE_ACCA_FL, 16'h0000, 8'h00);
            run(cai_pkg::OP_LOAD_ACCA, {8'h00, daa_tab[i][7:0]}, 8'h00);
            run(cai_pkg::OP_DECIMAL_ADJUST, 16'h0000, 8'h00);
        end
        foreach (ari[i])
        begin
            run(cai_pkg::OP_LOAD_PAIR, ari[i], 8'h00);
            run(cai_pkg::OP_ADD_ACCS, 16'h0000, 8'h00);
            run(cai_pkg::OP_LOAD_PAIR, ari[i], 8'h00);
            run(cai_pkg::OP_CMP_ACCS, 16'h0000, 8'h00);
            run(cai_pkg::OP_SUB_ACCS, 16'h0000, 8'h00);
        end
        $display("Test accumulator arithmetic done");
        run(cai_pkg::OP_LOAD_INDEX_ONE, 16'hFFFF, 8'h00);
        run(cai_pkg::OP_INC_INDEX_ONE, 16'h0000, 8'h00);
        run(cai_pkg::OP_DEC_INDEX_ONE, 16'h0000, 8'h00);
        run(cai_pkg::OP_LOAD_PAIR, 16'h00FF, 8'h00);
        run(cai_pkg::OP_LOAD_INDEX_ONE, 16'hFF80, 8'h00);
        run(cai_pkg::OP_ADD_ACCB_IX1, 16'h0000, 8'h00);
        run(cai_pkg::OP_LOAD_INDEX_TWO, 16'hFFF0, 8'h00);
        run(cai_pkg::OP_ADD_ACCB_IX2, 16'h0000, 8'h00);
        run(cai_pkg::OP_ADDR_INDEX_ONE, 16'h0000, 8'hFF);
        run(cai_pkg::OP_ADDR_INDEX_TWO, 16'h0000, 8'h80);
        // Held request during the busy slot must be taken once only
        issue(cai_pkg::OP_ADDR_INDEX_TWO, 16'h0000, 8'h01);
        issue(cai_pkg::OP_INC_INDEX_ONE, 16'h0000, 8'h00);
        @(negedge core_clk);
        op_valid = 1'b0;
        check_all();
        $display("Test index registers done");
        repeat (300)
            run(cai_pkg::cai_op_t'($urandom_range(19, 1)), 16'($urandom), 8'($urandom));
        $display("Test random operations done");
        complete_run();
    end
endmodule : cpu_accumulator_index_regs_tb
